// ===== src/raf_map.vh
// Constants for the receive destination-address filter.
`ifndef RAF_MAP_VH
`define RAF_MAP_VH

// ==========================================================
// Register byte offsets
`define RAF_CTRL_OFF      8'h00
`define RAF_STATUS_OFF    8'h04
`define RAF_INT_STAT_OFF  8'h08
`define RAF_INT_MASK_OFF  8'h0c

// ==========================================================
// Control register fields
`define RAF_CTRL_HASH_ONE  0
`define RAF_CTRL_INVERSE   1
`define RAF_CTRL_GROUP     2
`define RAF_CTRL_ALL_GRP   3
`define RAF_CTRL_NO_DA     4
`define RAF_CTRL_ALL_FRM   5
`define RAF_CTRL_OWN_CRC   6
`define RAF_CTRL_W         7
`define RAF_CTRL_RST       7'h00

// ==========================================================
// Status register fields
`define RAF_ST_BUSY        0
`define RAF_ST_HIT         1
`define RAF_ST_FAULT       2
`define RAF_ST_CTRL_HIT    3
`define RAF_ST_IDX_LO      16

// ==========================================================
// Interrupt status and mask fields
`define RAF_INT_DONE       0
`define RAF_INT_FAULT      1
`define RAF_INT_W          2
`define RAF_INT_RST        2'h0

// ==========================================================
// Filtering constants
`define RAF_CRC_POLY       32'hedb88320
`define RAF_CRC_INIT       32'hffffffff
`define RAF_CTRL_FRAME_DA  48'h0180c2000001
`define RAF_GROUP_BIT      40
`define RAF_DA_BYTES       6
`define RAF_ENTRIES        16
`define RAF_ONE_WORD_HI    4'he
`define RAF_ONE_WORD_MID   4'hf
`define RAF_ONE_WORD_LO    4'h0
`define RAF_LAST_ENTRY     4'hf

`endif

// ===== src/raf_rx_address_filter.v
// Receive destination-address filter with APB control and status.
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "raf_map.vh"

module raf_rx_address_filter #(
  parameter ADDR_W = 8
) (
  // Clock and reset.
  input wire pclk,
  input wire presetn,
  // APB slave.
  input wire [ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Interrupt.
  output reg irq,
  // Receive frame engine.
  input wire search_request_toggle,
  input wire search_cancel,
  input wire [8:0] table_bit_index,
  input wire [47:0] frame_destination,
  // Table memory.
  output reg [3:0] table_read_index,
  input wire [47:0] table_read_word,
  // Results.
  output reg filter_hit,
  output reg filter_fault,
  output reg control_frame_hit,
  output reg gated_clock_allow
);

  // ==========================================================
  // Declarations
  // Search states; ST_ONE walks the single perfect address.
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_HASH = 3'd1;
  localparam [2:0] ST_PERF = 3'd2;
  localparam [2:0] ST_ONE = 3'd3;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg toggle_q;
  reg [47:0] dest_q;
  reg [8:0] bidx_q;
  reg [1:0] one_step_q;
  reg [1:0] one_step_d;
  reg [3:0] rd_idx_d;
  reg hit_d;
  reg fault_d;
  reg ctl_hit_d;
  reg finish_d;
  reg [`RAF_CTRL_W-1:0] ctrl_q;
  reg [`RAF_INT_W-1:0] int_stat_q;
  reg [`RAF_INT_W-1:0] int_mask_q;
  reg [31:0] rd_mux;
  reg rd_bad;
  reg [31:0] crc_v;
  reg fb;
  integer i;

  // A request is any change of the toggle since the last cycle.
  // Changes seen while busy are absorbed, since toggle_q always follows.
  wire new_req = search_request_toggle ^ toggle_q;
  wire group_da = frame_destination[`RAF_GROUP_BIT];
  wire wr_en = psel & penable & pwrite & pready;
  wire hash_plus_one_select = ctrl_q[`RAF_CTRL_HASH_ONE];
  wire inverse_filter_enable = ctrl_q[`RAF_CTRL_INVERSE];
  wire imperfect_group_only = ctrl_q[`RAF_CTRL_GROUP];
  wire accept_all_group = ctrl_q[`RAF_CTRL_ALL_GRP];
  wire no_da_filter_enable = ctrl_q[`RAF_CTRL_NO_DA];
  wire accept_every_frame = ctrl_q[`RAF_CTRL_ALL_FRM];
  wire own_crc = ctrl_q[`RAF_CTRL_OWN_CRC];
  wire [8:0] launch_idx;
  wire hash_bit;
  wire [`RAF_INT_W-1:0] int_set;

  // ==========================================================
  // Hash index from CRC of the destination bytes, first byte
  // (bits 47:40) first and each byte least significant bit first.
  always @* begin
    crc_v = `RAF_CRC_INIT;
    fb = 1'b0;
    for (i = 0; i < `RAF_DA_BYTES * 8; i = i + 1) begin
      fb = crc_v[0] ^ frame_destination[47 - (i / 8) * 8 - 7 + (i % 8)];
      crc_v = {1'b0, crc_v[31:1]};
      if (fb) begin
        crc_v = crc_v ^ `RAF_CRC_POLY;
      end
    end
    // The result is taken complemented, as it would be sent.
    crc_v = ~crc_v;
  end

  // The top nine bits of the CRC, or the engine's own index.
  assign launch_idx = own_crc ? crc_v[31:23] : table_bit_index;

  // Bit of the 512-bit table: word from index[8:5], bit from [4:0].
  assign hash_bit = table_read_word[bidx_q[4:0]];

  // ==========================================================
  // Search state machine: next state, read index and results.
  always @* begin
    state_d = state_q;
    one_step_d = one_step_q;
    rd_idx_d = table_read_index;
    hit_d = filter_hit;
    fault_d = filter_fault;
    ctl_hit_d = control_frame_hit;
    finish_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (new_req && !search_cancel) begin
          hit_d = 1'b0;
          fault_d = 1'b0;
          ctl_hit_d = 1'b0;
          if (frame_destination == `RAF_CTRL_FRAME_DA) begin
            hit_d = 1'b1;
            ctl_hit_d = 1'b1;
            finish_d = 1'b1;
          end else if (no_da_filter_enable) begin
            hit_d = 1'b1;
            finish_d = 1'b1;
          end else if (accept_every_frame) begin
            hit_d = 1'b1;
            finish_d = 1'b1;
          end else if (accept_all_group && group_da) begin
            hit_d = 1'b1;
            finish_d = 1'b1;
          end else if (hash_plus_one_select) begin
            if (imperfect_group_only && !group_da) begin
              state_d = ST_ONE;
              one_step_d = 2'd0;
              rd_idx_d = `RAF_ONE_WORD_HI;
            end else begin
              state_d = ST_HASH;
              rd_idx_d = launch_idx[8:5];
            end
          end else begin
            state_d = ST_PERF;
            rd_idx_d = 4'h0;
          end
        end
      end
      ST_HASH: begin
        if (hash_bit) begin
          hit_d = 1'b1;
          state_d = ST_IDLE;
          finish_d = 1'b1;
        end else begin
          // A clear hash bit still leaves the one perfect address.
          state_d = ST_ONE;
          one_step_d = 2'd0;
          rd_idx_d = `RAF_ONE_WORD_HI;
        end
      end
      ST_PERF: begin
        // One stored address per cycle, all sixteen if needed.
        if (table_read_word == dest_q) begin
          hit_d = ~inverse_filter_enable;
          state_d = ST_IDLE;
          finish_d = 1'b1;
        end else if (table_read_index == `RAF_LAST_ENTRY) begin
          hit_d = inverse_filter_enable;
          state_d = ST_IDLE;
          finish_d = 1'b1;
        end else begin
          rd_idx_d = table_read_index + 4'h1;
        end
      end
      ST_ONE: begin
        // The single address sits in the top 16 bits of three words.
        case (one_step_q)
          2'd0: begin
            if (table_read_word[47:32] != dest_q[47:32]) begin
              state_d = ST_IDLE;
              finish_d = 1'b1;
            end else begin
              one_step_d = 2'd1;
              rd_idx_d = `RAF_ONE_WORD_MID;
            end
          end
          2'd1: begin
            if (table_read_word[47:32] != dest_q[31:16]) begin
              state_d = ST_IDLE;
              finish_d = 1'b1;
            end else begin
              one_step_d = 2'd2;
              rd_idx_d = `RAF_ONE_WORD_LO;
            end
          end
          default: begin
            hit_d = (table_read_word[47:32] == dest_q[15:0]);
            state_d = ST_IDLE;
            finish_d = 1'b1;
          end
        endcase
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // Cancel wins over everything while a search is running.
    if (search_cancel && state_q != ST_IDLE) begin
      state_d = ST_IDLE;
      hit_d = 1'b0;
      fault_d = 1'b1;
      finish_d = 1'b1;
    end
  end

  // Search registers and result outputs.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      toggle_q <= 1'b0;
      dest_q <= 48'h0;
      bidx_q <= 9'h0;
      one_step_q <= 2'd0;
      table_read_index <= 4'h0;
      filter_hit <= 1'b0;
      filter_fault <= 1'b0;
      control_frame_hit <= 1'b0;
      gated_clock_allow <= 1'b0;
    end else begin
      toggle_q <= search_request_toggle;
      // Latch address and index only at launch, so a swallowed request
      // cannot disturb the words that a running scan compares against.
      if (state_q == ST_IDLE && new_req) begin
        dest_q <= frame_destination;
        bidx_q <= launch_idx;
      end
      state_q <= state_d;
      one_step_q <= one_step_d;
      table_read_index <= rd_idx_d;
      filter_hit <= hit_d;
      filter_fault <= fault_d;
      control_frame_hit <= ctl_hit_d;
      // Clock runs only while a search is in flight.
      gated_clock_allow <= (state_d != ST_IDLE);
    end
  end

  // ==========================================================
  // Interrupt events: search finished, search faulted.
  // Both bits follow the finishing edge, so they line up with results.
  assign int_set = {finish_d & fault_d, finish_d};

  // Sticky status, write one to clear; a new event wins.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= `RAF_INT_RST;
      irq <= 1'b0;
    end else begin
      if (wr_en && paddr == `RAF_INT_STAT_OFF) begin
        int_stat_q <= (int_stat_q & ~pwdata[`RAF_INT_W-1:0]) | int_set;
      end else begin
        int_stat_q <= int_stat_q | int_set;
      end
      // Level output, one cycle behind the sticky bits and the mask.
      irq <= |(int_stat_q & int_mask_q);
    end
  end

  // ==========================================================
  // APB read mux and unmapped address detection.
  always @* begin
    rd_mux = 32'h0;
    rd_bad = 1'b0;
    case (paddr)
      `RAF_CTRL_OFF: begin
        rd_mux[`RAF_CTRL_W-1:0] = ctrl_q;
      end
      `RAF_STATUS_OFF: begin
        // Live busy flag, latched results and the index in use.
        rd_mux[`RAF_ST_BUSY] = (state_q != ST_IDLE);
        rd_mux[`RAF_ST_HIT] = filter_hit;
        rd_mux[`RAF_ST_FAULT] = filter_fault;
        rd_mux[`RAF_ST_CTRL_HIT] = control_frame_hit;
        rd_mux[`RAF_ST_IDX_LO+8:`RAF_ST_IDX_LO] = bidx_q;
      end
      `RAF_INT_STAT_OFF: begin
        rd_mux[`RAF_INT_W-1:0] = int_stat_q;
      end
      `RAF_INT_MASK_OFF: begin
        rd_mux[`RAF_INT_W-1:0] = int_mask_q;
      end
      default: begin
        rd_bad = 1'b1;
      end
    endcase
  end

  // APB slave: one wait state, then pready with registered data.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      ctrl_q <= `RAF_CTRL_RST;
      int_mask_q <= `RAF_INT_RST;
    end else begin
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h0 : rd_mux;
        pslverr <= rd_bad;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      // Writes land on the edge at which pready is seen high.
      // Unmapped addresses match no register and leave all unchanged.
      if (wr_en && paddr == `RAF_CTRL_OFF) begin
        ctrl_q <= pwdata[`RAF_CTRL_W-1:0];
      end
      if (wr_en && paddr == `RAF_INT_MASK_OFF) begin
        int_mask_q <= pwdata[`RAF_INT_W-1:0];
      end
    end
  end

endmodule

// ===== testbench/raf_properties.sv
// Port checker for the receive destination-address filter.
`timescale 1ns/100ps
`include "raf_map.vh"
module raf_properties #(
  parameter ADDR_W = 8
) (
  // Clock, reset and APB.
  input wire pclk,
  input wire presetn,
  input wire [ADDR_W-1:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  input wire pready,
  // Search side.
  input wire search_request_toggle,
  input wire search_cancel,
  input wire [47:0] frame_destination,
  input wire [3:0] table_read_index,
  input wire filter_hit,
  input wire filter_fault,
  input wire control_frame_hit,
  input wire gated_clock_allow
);
  // ==========================================================
  // Helper state
  reg [6:0] ctrl_q;
  reg tog_q;
  wire launch = (search_request_toggle ^ tog_q) & ~gated_clock_allow &
    ~search_cancel;
  wire is_cf = frame_destination == `RAF_CTRL_FRAME_DA;
  // Shadows the control word and the last sampled request level.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 7'h00;
      tog_q <= 1'b0;
    end else begin
      tog_q <= search_request_toggle;
      if (psel && penable && pready && pwrite && paddr == `RAF_CTRL_OFF) begin
        ctrl_q <= pwdata[6:0];
      end
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_cancel_to_idle:
    assert property (gated_clock_allow && search_cancel
      |=> !gated_clock_allow && filter_fault && !filter_hit)
    else $error("cancel did not end the search with a fault");
  chk_ctrl_frame_hit:
    assert property (launch && is_cf |=> control_frame_hit)
    else $error("control frame address not reported");
  chk_nofilter_hit:
    assert property (launch && !is_cf && ctrl_q[4] |=> filter_hit)
    else $error("no-filter mode did not pass the frame");
  chk_every_frame_hit:
    assert property (launch && !is_cf && ctrl_q[5] |=> filter_hit)
    else $error("accept-every mode did not pass the frame");
  chk_all_group_hit:
    assert property (launch && !is_cf && ctrl_q[3] && frame_destination[40]
      |=> filter_hit)
    else $error("group frame not passed in accept-all-group mode");
  chk_search_starts:
    assert property (launch && !is_cf && ctrl_q[5:3] == 3'h0
      |=> gated_clock_allow)
    else $error("request toggle did not start a search");
  chk_busy_no_result:
    assert property (gated_clock_allow |-> !filter_hit && !filter_fault)
    else $error("result shown while search busy");
  chk_scan_bounded:
    assert property ($rose(gated_clock_allow) && !ctrl_q[0]
      |-> ##[1:17] !gated_clock_allow)
    else $error("perfect scan ran past sixteen entries");
  chk_index_steps:
    assert property (gated_clock_allow && $past(gated_clock_allow)
      && !ctrl_q[0] |-> table_read_index == $past(table_read_index) + 4'h1)
    else $error("perfect scan skipped a table entry");
endmodule

bind raf_rx_address_filter raf_properties #(.ADDR_W(ADDR_W)) u_raf_properties (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready,
  .search_request_toggle, .search_cancel, .frame_destination,
  .table_read_index, .filter_hit, .filter_fault, .control_frame_hit,
  .gated_clock_allow);

// ===== testbench/raf_table_model.sv
// Table memory model that answers the filter's read index.
`timescale 1ns/100ps
module raf_table_model (
  // Read port.
  input wire [3:0] table_read_index,
  output wire [47:0] table_read_word
);
  // Sixteen 48-bit words, filled by the bench.
  reg [47:0] mem [0:15];
  // Read is combinational, in the same cycle as the index.
  assign table_read_word = mem[table_read_index];
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the receive destination-address filter.
`timescale 1ns/100ps
`include "raf_map.vh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED at %0t: value differs", $time); end end
module tb;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [7:0] paddr = 0;
  reg [31:0] pwdata = 0, rd;
  reg search_request_toggle = 0, search_cancel = 0, err;
  reg [8:0] table_bit_index = 0, h;
  reg [47:0] frame_destination = 0;
  reg [65:0] rows [0:11];
  wire [31:0] prdata;
  wire [47:0] table_read_word;
  wire [3:0] table_read_index;
  wire pready, pslverr, irq, filter_hit, filter_fault;
  wire control_frame_hit, gated_clock_allow;
  integer n_mismatch = 0, cmp_count = 0, i, k;
  // ==========================================================
  // Design, table model and clock
  raf_rx_address_filter u_raf_rx_address_filter (.pclk, .presetn, .paddr,
    .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .irq,
    .search_request_toggle, .search_cancel, .table_bit_index,
    .frame_destination, .table_read_index, .table_read_word, .filter_hit,
    .filter_fault, .control_frame_hit, .gated_clock_allow);
  raf_table_model u_raf_table_model (.table_read_index, .table_read_word);
  // The clock toggles every 12.5 ns, for a period of 25 ns.
  always #12.5 pclk = ~pclk;
  // ==========================================================
  // Tasks
  // Closes the run with the counts and the verdict.
  task print_verdict;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  // One APB transfer; waits for pready under a bound.
  task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge pclk);
        k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k == 20) begin
        $display("CHECK FAILED at %0t: bus timeout", $time);
        n_mismatch++;
        print_verdict;
      end
    end
  endtask
  // Starts a search and waits until the filter is idle again.
  task search(input reg [47:0] d, input reg [8:0] b);
    begin
      @(posedge pclk);
      frame_destination <= d;
      table_bit_index <= b;
      search_request_toggle <= ~search_request_toggle;
      repeat (2) @(posedge pclk);
      k = 0;
      while (gated_clock_allow !== 1'b0 && k < 40) begin
        @(posedge pclk);
        k++;
      end
      if (k == 40) begin
        $display("CHECK FAILED at %0t: search timeout", $time);
        n_mismatch++;
        print_verdict;
      end
    end
  endtask
  // Reference hash index: reflected CRC over six bytes, top nine bits.
  function [8:0] crc_top9(input [47:0] d);
    reg [31:0] c;
    integer j;
    begin
      c = `RAF_CRC_INIT;
      for (j = 0; j < 48; j++) begin
        c = (c >> 1) ^ ((c[0] ^ d[40 - (j / 8) * 8 + j % 8]) ?
          `RAF_CRC_POLY : 32'h0);
      end
      crc_top9 = ~c[31:23];
    end
  endfunction
  // ==========================================================
  // Main sequence
  initial begin
    // Rows: control, destination, index, expected hit, control-frame hit.
    rows[0] = {7'h00, 48'h020000000005, 9'h000, 2'b10};
    rows[1] = {7'h00, 48'h0200000000a5, 9'h000, 2'b00};
    rows[2] = {7'h02, 48'h020000000005, 9'h000, 2'b00};
    rows[3] = {7'h02, 48'h0200000000a5, 9'h000, 2'b10};
    rows[4] = {7'h00, 48'h02000000000f, 9'h000, 2'b10};
    rows[5] = {7'h01, 48'h010000000000, 9'h020, 2'b10};
    rows[6] = {7'h01, 48'h010000000000, 9'h021, 2'b00};
    rows[7] = {7'h01, 48'h020002000200, 9'h021, 2'b10};
    rows[8] = {7'h05, 48'h020000000000, 9'h020, 2'b00};
    rows[9] = {7'h08, 48'h010000000000, 9'h021, 2'b10};
    rows[10] = {7'h10, 48'h0200000000a5, 9'h000, 2'b10};
    rows[11] = {7'h20, 48'h0200000000a5, 9'h000, 2'b10};
    for (i = 0; i < 16; i++) begin
      u_raf_table_model.mem[i] = 48'h020000000000 | i;
    end
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 12; i++) begin
      apb(1'b1, `RAF_CTRL_OFF, {25'h0, rows[i][65:59]});
      search(rows[i][58:11], rows[i][10:2]);
      `CHK(filter_hit, rows[i][1])
      `CHK({control_frame_hit, filter_fault}, {rows[i][0], 1'b0})
    end
    // Control frame address and the internal hash in both directions.
    apb(1'b1, `RAF_CTRL_OFF, 32'h0);
    search(`RAF_CTRL_FRAME_DA, 9'h000);
    `CHK(control_frame_hit, 1'b1)
    apb(1'b1, `RAF_CTRL_OFF, 32'h41);
    h = crc_top9(48'h01005e000001);
    u_raf_table_model.mem[h[8:5]][h[4:0]] = 1'b1;
    search(48'h01005e000001, ~h);
    `CHK(filter_hit, 1'b1)
    apb(1'b0, `RAF_STATUS_OFF, 32'h0);
    `CHK(rd, {7'h0, h, 16'h0002})
    u_raf_table_model.mem[h[8:5]][h[4:0]] = 1'b0;
    search(48'h01005e000001, ~h);
    `CHK(filter_hit, 1'b0)
    // Cancel in mid-scan, then the fault interrupt.
    apb(1'b1, `RAF_CTRL_OFF, 32'h0);
    @(posedge pclk);
    frame_destination <= 48'h0200000000a5;
    search_request_toggle <= ~search_request_toggle;
    repeat (3) @(posedge pclk);
    search_cancel <= 1'b1;
    @(posedge pclk);
    search_cancel <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({filter_hit, filter_fault, gated_clock_allow}, 3'b010)
    `CHK(irq, 1'b0)
    apb(1'b1, `RAF_INT_MASK_OFF, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b1)
    apb(1'b1, `RAF_INT_STAT_OFF, 32'h3);
    repeat (2) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b0, 8'h10, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // Reset in mid-run clears outputs and the control word.
    apb(1'b1, `RAF_CTRL_OFF, 32'h3f);
    presetn <= 1'b0;
    search_request_toggle <= 1'b0;
    repeat (2) @(posedge pclk);
    `CHK({filter_hit, filter_fault, irq, gated_clock_allow}, 4'h0)
    presetn <= 1'b1;
    apb(1'b0, `RAF_CTRL_OFF, 32'h0);
    `CHK(rd, 32'h0)
    print_verdict;
  end
endmodule
